/* src/lpmc_ahb_slave.sv */
// AHB-Lite slave front end: address phase capture, write strobe, read data.
`timescale 1ns/100ps
module lpmc_ahb_slave (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] rd_word,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic [7:0] rd_addr,
	output lpmc_pkg::lpmc_wr_s wr
);
	logic ph_write;
	logic [7:0] ph_addr;
	wire take = hsel && htrans[1] && hready && clk_en &&
		hsize == lpmc_pkg::HSIZE_WORD;

	// The slave never inserts waits of its own; a frozen block stalls the bus.
	assign hreadyout = clk_en;
	assign hresp = 1'b0;
	assign rd_addr = haddr[7:0];
	assign wr.valid = ph_write && clk_en;
	assign wr.addr = ph_addr;
	assign wr.data = hwdata;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_write <= 1'b0;
			ph_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
		end else if (clk_en) begin
			ph_write <= take && hwrite;
			ph_addr <= haddr[7:0];
			if (take && !hwrite) begin
				hrdata <= rd_word;
			end
		end
	end
endmodule

/* src/lpmc_pkg.sv */
// Constants, state codes and carriers shared by the low-power controller.
package lpmc_pkg;
	localparam int NUM_IRQ = 8;
	localparam int NUM_EV = 4;
	localparam logic [7:0] OFS_STANDBY_CONTROL = 8'h00;
	localparam logic [7:0] OFS_RESET_STATUS_0 = 8'h04;
	localparam logic [7:0] OFS_EVENT_LINK = 8'h08;
	localparam logic [7:0] OFS_WAKE_ENABLE = 8'h0C;
	localparam logic [7:0] OFS_SNOOZE_REQ_EN = 8'h10;
	localparam logic [7:0] OFS_SNOOZE_WAKE_EN = 8'h14;
	localparam logic [7:0] OFS_INT_STATUS = 8'h18;
	localparam logic [7:0] OFS_INT_CLEAR = 8'h1C;
	localparam logic [7:0] OFS_INT_ENABLE = 8'h20;
	localparam logic [7:0] OFS_MODE_STATE = 8'h24;
	localparam logic [1:0] MODE_SLEEP = 2'h0;
	localparam logic [1:0] MODE_SW_STANDBY = 2'h1;
	localparam logic [1:0] MODE_DEEP = 2'h2;
	localparam logic [1:0] RST_STANDBY_CONTROL = 2'h0;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [3:0] RST_EV = 4'h0;
	localparam int DEEP_FLAG_BIT = 0;
	localparam int EV_ENTER = 0;
	localparam int EV_WAKE = 1;
	localparam int EV_SNOOZE = 2;
	localparam int EV_RESET_EXIT = 3;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [4:0] {
		ST_NORMAL = 5'h01,
		ST_SLEEP = 5'h02,
		ST_SW_STANDBY = 5'h04,
		ST_SNOOZE = 5'h08,
		ST_DEEP = 5'h10
	} lpmc_state_e;

	typedef struct packed {
		logic core_halt;
		logic periph_clk_en;
		logic snooze_clk_en;
		logic osc_en;
		logic periph_pwr_en;
		logic retain;
		logic keep_rtc_usb;
	} lpmc_pwr_s;

	localparam lpmc_pwr_s PWR_NORMAL = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1,
		1'b1, 1'b1};

	typedef struct packed {
		logic valid;
		logic [7:0] addr;
		logic [31:0] data;
	} lpmc_wr_s;
endpackage

/* src/lpmc_sticky.sv */
// Sticky event status with write-one-to-clear, enable mask and interrupt.
`timescale 1ns/100ps
module lpmc_sticky (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic [lpmc_pkg::NUM_EV-1:0] ev_set,
	input wire logic clr_we,
	input wire logic en_we,
	input wire logic [31:0] wdata,
	output logic [lpmc_pkg::NUM_EV-1:0] status,
	output logic [lpmc_pkg::NUM_EV-1:0] enable,
	output logic irq
);
	logic [lpmc_pkg::NUM_EV-1:0] next_status;
	wire [lpmc_pkg::NUM_EV-1:0] next_enable =
		en_we ? wdata[lpmc_pkg::NUM_EV-1:0] : enable;

	genvar i;
	generate
		for (i = 0; i < lpmc_pkg::NUM_EV; i++) begin : g_bit
			// A new event beats a clear landing in the same cycle.
			assign next_status[i] = ev_set[i] ||
				(status[i] && !(clr_we && wdata[i]));
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status <= lpmc_pkg::RST_EV;
			enable <= lpmc_pkg::RST_EV;
			irq <= 1'b0;
		end else if (clk_en) begin
			status <= next_status;
			enable <= next_enable;
			irq <= |(next_status & next_enable);
		end
	end
endmodule

/* src/lpmc_top.sv */
// Low-power mode controller: mode state machine, registers, power controls.
// Function
// - Sleep halts the core and keeps its internal registers.
// - Sleep leaves every peripheral clock running.
// - Any linked interrupt or any reset ends sleep.
// - Software standby stops core, most peripherals and oscillators.
// - Software standby keeps core, SRAM, peripheral and port state.
// - Snooze runs a few peripherals while the core stays halted.
// - Snooze is entered only from standby on an enabled snooze request.
// - An enabled snooze wake interrupt ends snooze.
// - Deep standby removes power from core and most peripherals.
// - Deep standby loses state except RTC alarm, interval, USB detect.
// - Reset pin, power-on, voltage monitor or interrupt cancel modes.
// - A reset ending deep standby sets the deep standby reset flag.
// - The wait instruction never leads into snooze.
// - Software picks the mode, then the wait instruction enters it.
`timescale 1ns/100ps
module lpmc_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic wait_for_interrupt_instr,
	input wire logic [lpmc_pkg::NUM_IRQ-1:0] irq_req,
	input wire logic snooze_done,
	input wire logic external_reset_pin_n,
	input wire logic por_evt,
	input wire logic vmon_evt,
	output lpmc_pkg::lpmc_pwr_s pwr,
	output logic core_resume,
	output logic sys_reset_req,
	output logic irq
);
	lpmc_pkg::lpmc_state_e state;
	lpmc_pkg::lpmc_state_e next_state;
	lpmc_pkg::lpmc_pwr_s next_pwr;
	lpmc_pkg::lpmc_wr_s wr;
	logic [7:0] rd_addr;
	logic [31:0] rd_word;
	logic [1:0] standby_control;
	logic [7:0] event_link_select_n;
	logic [7:0] wake_enable;
	logic [7:0] snooze_req_en;
	logic [7:0] snooze_wake_en;
	logic deep_standby_reset_flag;
	logic [lpmc_pkg::NUM_EV-1:0] ev_set;
	logic [lpmc_pkg::NUM_EV-1:0] int_status;
	logic [lpmc_pkg::NUM_EV-1:0] int_enable;

	lpmc_ahb_slave u_bus (
		.hclk(hclk),
		.hresetn(hresetn),
		.clk_en(clk_en),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.rd_word(rd_word),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.rd_addr(rd_addr),
		.wr(wr)
	);

	wire we_stby = wr.valid && wr.addr == lpmc_pkg::OFS_STANDBY_CONTROL;
	wire we_rst = wr.valid && wr.addr == lpmc_pkg::OFS_RESET_STATUS_0;
	wire we_link = wr.valid && wr.addr == lpmc_pkg::OFS_EVENT_LINK;
	wire we_wake = wr.valid && wr.addr == lpmc_pkg::OFS_WAKE_ENABLE;
	wire we_sreq = wr.valid && wr.addr == lpmc_pkg::OFS_SNOOZE_REQ_EN;
	wire we_swk = wr.valid && wr.addr == lpmc_pkg::OFS_SNOOZE_WAKE_EN;
	wire we_clr = wr.valid && wr.addr == lpmc_pkg::OFS_INT_CLEAR;
	wire we_ien = wr.valid && wr.addr == lpmc_pkg::OFS_INT_ENABLE;

	assign rd_word =
		(rd_addr == lpmc_pkg::OFS_STANDBY_CONTROL) ? 32'(standby_control) :
		(rd_addr == lpmc_pkg::OFS_RESET_STATUS_0) ?
			32'(deep_standby_reset_flag) :
		(rd_addr == lpmc_pkg::OFS_EVENT_LINK) ? 32'(event_link_select_n) :
		(rd_addr == lpmc_pkg::OFS_WAKE_ENABLE) ? 32'(wake_enable) :
		(rd_addr == lpmc_pkg::OFS_SNOOZE_REQ_EN) ? 32'(snooze_req_en) :
		(rd_addr == lpmc_pkg::OFS_SNOOZE_WAKE_EN) ? 32'(snooze_wake_en) :
		(rd_addr == lpmc_pkg::OFS_INT_STATUS) ? 32'(int_status) :
		(rd_addr == lpmc_pkg::OFS_INT_ENABLE) ? 32'(int_enable) :
		(rd_addr == lpmc_pkg::OFS_MODE_STATE) ? 32'(state) :
		32'h0000_0000;

	wire rst_any = !external_reset_pin_n || por_evt || vmon_evt;
	wire in_lpm = state != lpmc_pkg::ST_NORMAL;
	wire sleep_wake = |(irq_req & event_link_select_n);
	wire stby_wake = |(irq_req & wake_enable);
	wire snz_go = |(irq_req & snooze_req_en);
	wire snz_wake = |(irq_req & snooze_wake_en);

	// Resets take priority over every interrupt wake-up.
	always_comb begin
		next_state = state;
		unique case (state)
			lpmc_pkg::ST_NORMAL: begin
				if (wait_for_interrupt_instr) begin
					if (standby_control == lpmc_pkg::MODE_SLEEP) begin
						next_state = lpmc_pkg::ST_SLEEP;
					end else if (standby_control ==
						lpmc_pkg::MODE_SW_STANDBY) begin
						next_state = lpmc_pkg::ST_SW_STANDBY;
					end else if (standby_control == lpmc_pkg::MODE_DEEP) begin
						next_state = lpmc_pkg::ST_DEEP;
					end
				end
			end
			lpmc_pkg::ST_SLEEP: begin
				if (sleep_wake) begin
					next_state = lpmc_pkg::ST_NORMAL;
				end
			end
			lpmc_pkg::ST_SW_STANDBY: begin
				if (stby_wake) begin
					next_state = lpmc_pkg::ST_NORMAL;
				end else if (snz_go) begin
					next_state = lpmc_pkg::ST_SNOOZE;
				end
			end
			lpmc_pkg::ST_SNOOZE: begin
				if (snz_wake) begin
					next_state = lpmc_pkg::ST_NORMAL;
				end else if (snooze_done) begin
					next_state = lpmc_pkg::ST_SW_STANDBY;
				end
			end
			lpmc_pkg::ST_DEEP: begin
				if (stby_wake) begin
					next_state = lpmc_pkg::ST_NORMAL;
				end
			end
			default: next_state = lpmc_pkg::ST_NORMAL;
		endcase
		if (in_lpm && rst_any) begin
			next_state = lpmc_pkg::ST_NORMAL;
		end
	end

	always_comb begin
		next_pwr = lpmc_pkg::PWR_NORMAL;
		unique case (next_state)
			lpmc_pkg::ST_NORMAL: next_pwr = lpmc_pkg::PWR_NORMAL;
			lpmc_pkg::ST_SLEEP: begin
				next_pwr.core_halt = 1'b1;
			end
			lpmc_pkg::ST_SW_STANDBY: begin
				next_pwr.core_halt = 1'b1;
				next_pwr.periph_clk_en = 1'b0;
				next_pwr.snooze_clk_en = 1'b0;
				next_pwr.osc_en = 1'b0;
			end
			lpmc_pkg::ST_SNOOZE: begin
				next_pwr.core_halt = 1'b1;
				next_pwr.periph_clk_en = 1'b0;
				next_pwr.osc_en = 1'b0;
			end
			lpmc_pkg::ST_DEEP: begin
				next_pwr.core_halt = 1'b1;
				next_pwr.periph_clk_en = 1'b0;
				next_pwr.snooze_clk_en = 1'b0;
				next_pwr.osc_en = 1'b0;
				next_pwr.periph_pwr_en = 1'b0;
				next_pwr.retain = 1'b0;
			end
			default: next_pwr = lpmc_pkg::PWR_NORMAL;
		endcase
	end

	assign ev_set[lpmc_pkg::EV_ENTER] = !in_lpm &&
		next_state != lpmc_pkg::ST_NORMAL;
	assign ev_set[lpmc_pkg::EV_WAKE] = in_lpm && !rst_any &&
		next_state == lpmc_pkg::ST_NORMAL;
	assign ev_set[lpmc_pkg::EV_SNOOZE] = state != lpmc_pkg::ST_SNOOZE &&
		next_state == lpmc_pkg::ST_SNOOZE;
	assign ev_set[lpmc_pkg::EV_RESET_EXIT] = in_lpm && rst_any;

	wire deep_rst_exit = state == lpmc_pkg::ST_DEEP && rst_any;
	// Leaving deep standby always goes through a reset of the system.
	wire next_sys_reset = (in_lpm && rst_any) ||
		(state == lpmc_pkg::ST_DEEP && next_state == lpmc_pkg::ST_NORMAL);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= lpmc_pkg::ST_NORMAL;
			pwr <= lpmc_pkg::PWR_NORMAL;
			core_resume <= 1'b0;
			sys_reset_req <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			pwr <= next_pwr;
			core_resume <= ev_set[lpmc_pkg::EV_WAKE];
			sys_reset_req <= next_sys_reset;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			deep_standby_reset_flag <= 1'b0;
		end else if (clk_en) begin
			if (deep_rst_exit) begin
				deep_standby_reset_flag <= 1'b1;
			end else if (we_rst && wr.data[lpmc_pkg::DEEP_FLAG_BIT]) begin
				deep_standby_reset_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			standby_control <= lpmc_pkg::RST_STANDBY_CONTROL;
			event_link_select_n <= lpmc_pkg::RST_MASK;
			wake_enable <= lpmc_pkg::RST_MASK;
			snooze_req_en <= lpmc_pkg::RST_MASK;
			snooze_wake_en <= lpmc_pkg::RST_MASK;
		end else if (clk_en) begin
			if (we_stby) standby_control <= wr.data[1:0];
			if (we_link) event_link_select_n <= wr.data[7:0];
			if (we_wake) wake_enable <= wr.data[7:0];
			if (we_sreq) snooze_req_en <= wr.data[7:0];
			if (we_swk) snooze_wake_en <= wr.data[7:0];
		end
	end

	lpmc_sticky u_int (
		.hclk(hclk),
		.hresetn(hresetn),
		.clk_en(clk_en),
		.ev_set(ev_set),
		.clr_we(we_clr),
		.en_we(we_ien),
		.wdata(wr.data),
		.status(int_status),
		.enable(int_enable),
		.irq(irq)
	);

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_snooze_cause;
		state == lpmc_pkg::ST_SW_STANDBY && clk_en && snz_go &&
			!stby_wake && !rst_any;
	endsequence
	sequence s_in_snooze;
		state == lpmc_pkg::ST_SNOOZE ##0 pwr.snooze_clk_en && pwr.core_halt;
	endsequence
	sequence s_sleep_wake;
		state == lpmc_pkg::ST_SLEEP && clk_en && sleep_wake;
	endsequence
	sequence s_resumed;
		state == lpmc_pkg::ST_NORMAL ##0 core_resume && !pwr.core_halt;
	endsequence

	a_sleep_core_hold: assert property (
		state == lpmc_pkg::ST_SLEEP |-> pwr.core_halt && pwr.retain)
		else $error("sleep does not halt and retain the core");
	a_sleep_periph_run: assert property (
		state == lpmc_pkg::ST_SLEEP |-> pwr.periph_clk_en && pwr.osc_en)
		else $error("sleep stopped peripheral clocks");
	a_sleep_wake_irq: assert property (
		s_sleep_wake and !rst_any |=> s_resumed)
		else $error("linked interrupt did not end sleep");
	a_stby_clocks_stop: assert property (
		state == lpmc_pkg::ST_SW_STANDBY |->
			pwr.core_halt && !pwr.periph_clk_en && !pwr.osc_en)
		else $error("standby left clocks running");
	a_stby_keep_state: assert property (
		state inside {lpmc_pkg::ST_SW_STANDBY, lpmc_pkg::ST_SNOOZE} |->
			pwr.retain && pwr.periph_pwr_en)
		else $error("standby lost retained state");
	a_snooze_entry: assert property (
		s_snooze_cause |=> s_in_snooze)
		else $error("snooze request not taken");
	a_snooze_only_stby: assert property (
		$rose(state == lpmc_pkg::ST_SNOOZE) |->
			$past(state) == lpmc_pkg::ST_SW_STANDBY && pwr.core_halt)
		else $error("snooze entered from a wrong mode");
	a_snooze_wake: assert property (
		state == lpmc_pkg::ST_SNOOZE && clk_en && snz_wake |=> s_resumed)
		else $error("snooze wake interrupt ignored");
	a_deep_power_off: assert property (
		state == lpmc_pkg::ST_DEEP |-> !pwr.periph_pwr_en &&
			!pwr.retain && pwr.keep_rtc_usb)
		else $error("deep standby power controls wrong");
	a_reset_cancel: assert property (
		in_lpm && clk_en && rst_any |=>
			state == lpmc_pkg::ST_NORMAL && sys_reset_req && !core_resume)
		else $error("reset did not cancel the mode");
	a_deep_reset_flag: assert property (
		state == lpmc_pkg::ST_DEEP && clk_en && rst_any |=>
			deep_standby_reset_flag [*2])
		else $error("deep standby reset flag not set");
	a_wfi_no_snooze: assert property (
		state == lpmc_pkg::ST_NORMAL |=> state != lpmc_pkg::ST_SNOOZE)
		else $error("snooze entered from normal mode");
	a_wfi_select: assert property (
		state == lpmc_pkg::ST_NORMAL && clk_en && wait_for_interrupt_instr &&
			standby_control == lpmc_pkg::MODE_SW_STANDBY |=>
			state == lpmc_pkg::ST_SW_STANDBY && !pwr.osc_en)
		else $error("selected standby mode not entered");
	a_wake_resume: assert property (
		$rose(core_resume) |-> $past(in_lpm) && pwr.osc_en &&
			pwr.periph_clk_en)
		else $error("core resumed with clocks stopped");
endmodule

/* verif/lpmc_core_model.sv */
// Behavioural core and interrupt source model facing the controller.
`timescale 1ns/100ps
module lpmc_core_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire lpmc_pkg::lpmc_pwr_s pwr,
	input wire logic do_wait,
	input wire logic [lpmc_pkg::NUM_IRQ-1:0] do_irq,
	output logic wait_for_interrupt_instr,
	output logic [lpmc_pkg::NUM_IRQ-1:0] irq_req
);
	// A halted core cannot execute another wait instruction.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_for_interrupt_instr <= 1'h0;
			irq_req <= 8'h00;
		end else begin
			wait_for_interrupt_instr <= do_wait & ~pwr.core_halt;
			irq_req <= do_irq;
		end
	end
endmodule

/* verif/lpmc_top_tb.sv */
// Self-checking bench for the low-power mode controller.
`timescale 1ns/100ps
module lpmc_top_tb;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] wd;
		logic [31:0] rv;
		logic [31:0] ev;
	} lpmc_row_s;
	logic hclk = 1'h0;
	logic hresetn = 1'h0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic wait_for_interrupt_instr;
	logic [7:0] irq_req;
	logic snooze_done = 1'h0;
	logic external_reset_pin_n = 1'h1;
	logic por_evt = 1'h0;
	logic vmon_evt = 1'h0;
	logic clk_en = 1'h1;
	logic [2:0] hsize = lpmc_pkg::HSIZE_WORD;
	logic do_wait = 1'h0;
	logic [7:0] do_irq = 8'h00;
	lpmc_pkg::lpmc_pwr_s pwr;
	logic core_resume;
	logic sys_reset_req;
	logic irq;
	logic [31:0] rd;
	int bad_count = 0;
	int compares = 0;
	int resume_cnt = 0;
	int reset_cnt = 0;
	logic [4:0] mcode [3] = '{5'h02, 5'h04, 5'h10};
	lpmc_row_s rows [11] = '{
		'{8'h00, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0003},
		'{8'h04, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000},
		'{8'h08, 32'h0000_00FF, 32'h0000_0000, 32'h0000_00FF},
		'{8'h0C, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_00FF},
		'{8'h10, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_00FF},
		'{8'h14, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_00FF},
		'{8'h18, 32'h0000_000F, 32'h0000_0000, 32'h0000_0000},
		'{8'h1C, 32'h0000_000F, 32'h0000_0000, 32'h0000_0000},
		'{8'h20, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_000F},
		'{8'h24, 32'h0000_00FF, 32'h0000_0001, 32'h0000_0001},
		'{8'h40, 32'h0000_00FF, 32'h0000_0000, 32'h0000_0000}
	};

	lpmc_top lpmc_top_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
		.hsel(1'h1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.wait_for_interrupt_instr(wait_for_interrupt_instr),
		.irq_req(irq_req), .snooze_done(snooze_done),
		.external_reset_pin_n(external_reset_pin_n), .por_evt(por_evt),
		.vmon_evt(vmon_evt), .pwr(pwr), .core_resume(core_resume),
		.sys_reset_req(sys_reset_req), .irq(irq));
	lpmc_core_model lpmc_core_model_inst (.hclk(hclk), .hresetn(hresetn),
		.pwr(pwr), .do_wait(do_wait), .do_irq(do_irq),
		.wait_for_interrupt_instr(wait_for_interrupt_instr),
		.irq_req(irq_req));

	initial begin
		forever #20 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		if (core_resume === 1'h1) resume_cnt++;
		if (sys_reset_req === 1'h1) reset_cnt++;
	end

	task test_done;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chkb(input logic got, input logic exp);
		chk({31'h0000_0000, got}, {31'h0000_0000, exp});
	endtask
	task hwait;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'h1 && n < 100) begin
			n++;
			@(posedge hclk);
		end
		if (n >= 100) begin
			bad_count++;
			test_done();
		end
	endtask
	// Address phase, then an idle data phase; read data taken at its end.
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'h2;
		hwait();
		htrans <= 2'h0;
		hwdata <= d;
		hwait();
		rd = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'h1, a, d);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'h0, a, 32'h0000_0000);
		chk(rd, exp);
		chkb(hresp, 1'h0);
	endtask
	task mode(input logic [4:0] m);
		rdc(lpmc_pkg::OFS_MODE_STATE, {27'h000_0000, m});
	endtask
	task go_wait;
		do_wait <= 1'h1;
		@(posedge hclk);
		do_wait <= 1'h0;
		repeat (3) @(posedge hclk);
	endtask
	task fire(input int i);
		do_irq <= 8'h01 << i;
		@(posedge hclk);
		do_irq <= 8'h00;
		repeat (3) @(posedge hclk);
	endtask
	// Causes 0 to 2 are reset pin, voltage monitor, power-on; 3 ends snooze.
	task cause(input int i);
		if (i == 0) external_reset_pin_n <= 1'h0;
		if (i == 1) vmon_evt <= 1'h1;
		if (i == 2) por_evt <= 1'h1;
		if (i == 3) snooze_done <= 1'h1;
		@(posedge hclk);
		external_reset_pin_n <= 1'h1;
		vmon_evt <= 1'h0;
		por_evt <= 1'h0;
		snooze_done <= 1'h0;
		repeat (3) @(posedge hclk);
	endtask

	initial begin
		#400000;
		bad_count++;
		test_done();
	end
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		chk({25'h000_0000, pwr}, {25'h000_0000, 7'h3F});
		foreach (rows[k]) begin
			rdc(rows[k].a, rows[k].rv);
			wr(rows[k].a, rows[k].wd);
			rdc(rows[k].a, rows[k].ev);
		end
		wr(lpmc_pkg::OFS_EVENT_LINK, 32'h0000_0001);
		wr(lpmc_pkg::OFS_WAKE_ENABLE, 32'h0000_0004);
		wr(lpmc_pkg::OFS_SNOOZE_REQ_EN, 32'h0000_0008);
		wr(lpmc_pkg::OFS_SNOOZE_WAKE_EN, 32'h0000_0010);
		wr(lpmc_pkg::OFS_STANDBY_CONTROL, 32'h0000_0000);
		go_wait();
		mode(5'h02);
		chkb(pwr.core_halt, 1'h1);
		chkb(pwr.periph_clk_en, 1'h1);
		fire(1);
		mode(5'h02);
		fire(0);
		mode(5'h01);
		chk(resume_cnt, 32'h0000_0001);
		chkb(pwr.core_halt, 1'h0);
		rdc(lpmc_pkg::OFS_INT_STATUS, 32'h0000_0003);
		chkb(irq, 1'h1);
		wr(lpmc_pkg::OFS_INT_CLEAR, 32'h0000_000F);
		rdc(lpmc_pkg::OFS_INT_STATUS, 32'h0000_0000);
		chkb(irq, 1'h0);
		wr(lpmc_pkg::OFS_INT_ENABLE, 32'h0000_0000);
		fire(3);
		mode(5'h01);
		wr(lpmc_pkg::OFS_STANDBY_CONTROL, 32'h0000_0001);
		go_wait();
		mode(5'h04);
		chkb(pwr.core_halt, 1'h1);
		chkb(pwr.osc_en, 1'h0);
		chkb(pwr.retain, 1'h1);
		chkb(irq, 1'h0);
		fire(3);
		mode(5'h08);
		chkb(pwr.snooze_clk_en, 1'h1);
		chkb(pwr.core_halt, 1'h1);
		cause(3);
		mode(5'h04);
		fire(2);
		mode(5'h01);
		chkb(pwr.osc_en, 1'h1);
		go_wait();
		fire(3);
		fire(4);
		mode(5'h01);
		chk(resume_cnt, 32'h0000_0003);
		for (int i = 0; i < 3; i++) begin
			wr(lpmc_pkg::OFS_STANDBY_CONTROL, 32'(i));
			go_wait();
			mode(mcode[i]);
			if (i == 2) begin
				chkb(pwr.periph_pwr_en, 1'h0);
				chkb(pwr.keep_rtc_usb, 1'h1);
			end
			cause(i);
			mode(5'h01);
			chk(reset_cnt, 32'(i + 1));
			rdc(lpmc_pkg::OFS_RESET_STATUS_0, 32'(i == 2));
			wr(lpmc_pkg::OFS_RESET_STATUS_0, 32'h0000_0001);
		end
		rdc(lpmc_pkg::OFS_RESET_STATUS_0, 32'h0000_0000);
		rdc(lpmc_pkg::OFS_INT_STATUS, 32'h0000_000F);
		// A write of a size other than a word must be dropped.
		hsize <= 3'h0;
		wr(lpmc_pkg::OFS_EVENT_LINK, 32'h0000_00FF);
		hsize <= lpmc_pkg::HSIZE_WORD;
		rdc(lpmc_pkg::OFS_EVENT_LINK, 32'h0000_0001);
		wr(lpmc_pkg::OFS_STANDBY_CONTROL, 32'h0000_0003);
		go_wait();
		mode(5'h01);
		wr(lpmc_pkg::OFS_STANDBY_CONTROL, 32'h0000_0000);
		go_wait();
		// A frozen block stalls the bus and ignores a linked interrupt.
		clk_en <= 1'h0;
		fire(0);
		chkb(hreadyout, 1'h0);
		clk_en <= 1'h1;
		mode(5'h02);
		hresetn <= 1'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		mode(5'h01);
		rdc(lpmc_pkg::OFS_EVENT_LINK, 32'h0000_0000);
		chk({25'h000_0000, pwr}, {25'h000_0000, 7'h3F});
		test_done();
	end
endmodule
